// [common/lom_pkg.sv]
package lom_pkg;
    // register word indices; each byte address is four times its index
    localparam logic [7:0]  LOM_IDX_VOLUME_MUTE  = 8'h1E;
    localparam logic [7:0]  LOM_IDX_FIRST_ROUTES = 8'h34;
    localparam logic [7:0]  LOM_IDX_SECOND_ROUTES = 8'h35;
    localparam logic [7:0]  LOM_IDX_REF_CTRL     = 8'h38;
    localparam logic [9:0]  LOM_ADDR_VOLUME_MUTE  = {LOM_IDX_VOLUME_MUTE, 2'b00};
    localparam logic [9:0]  LOM_ADDR_FIRST_ROUTES = {LOM_IDX_FIRST_ROUTES, 2'b00};
    localparam logic [9:0]  LOM_ADDR_SECOND_ROUTES = {LOM_IDX_SECOND_ROUTES, 2'b00};
    localparam logic [9:0]  LOM_ADDR_REF_CTRL     = {LOM_IDX_REF_CTRL, 2'b00};
    // volume / mute register fields
    localparam int          LOM_BIT_FIRST_NEG_MUTE  = 6;
    localparam int          LOM_BIT_FIRST_POS_MUTE  = 5;
    localparam int          LOM_BIT_FIRST_ATTEN     = 4;
    localparam int          LOM_BIT_SECOND_NEG_MUTE = 2;
    localparam int          LOM_BIT_SECOND_POS_MUTE = 1;
    localparam int          LOM_BIT_SECOND_ATTEN    = 0;
    // first pair route register fields
    localparam int          LOM_BIT_LEFT_MIX_TO_FIRST_NEG  = 6;
    localparam int          LOM_BIT_RIGHT_MIX_TO_FIRST_NEG = 5;
    localparam int          LOM_BIT_FIRST_MODE             = 4;
    localparam int          LOM_BIT_RIGHT_AMP_TO_FIRST_DIFF = 2;
    localparam int          LOM_BIT_LEFT_AMP_TO_FIRST_DIFF  = 1;
    localparam int          LOM_BIT_LEFT_MIX_TO_FIRST_POS  = 0;
    // second pair route register fields
    localparam int          LOM_BIT_RIGHT_MIX_TO_SECOND_NEG = 6;
    localparam int          LOM_BIT_LEFT_MIX_TO_SECOND_NEG  = 5;
    localparam int          LOM_BIT_SECOND_MODE             = 4;
    localparam int          LOM_BIT_LEFT_AMP_TO_SECOND_DIFF  = 2;
    localparam int          LOM_BIT_RIGHT_AMP_TO_SECOND_DIFF = 1;
    localparam int          LOM_BIT_RIGHT_MIX_TO_SECOND_POS = 0;
    // reference control field
    localparam int          LOM_BIT_MIDRAIL_BUF_EN = 0;
    // writable masks and reset values
    localparam logic [15:0] LOM_MASK_VOLUME_MUTE = 16'h0077;
    localparam logic [15:0] LOM_MASK_ROUTES      = 16'h0077;
    localparam logic [15:0] LOM_MASK_REF_CTRL    = 16'h0001;
    localparam logic [15:0] LOM_RST_VOLUME_MUTE  = 16'h0066;
    localparam logic [15:0] LOM_RST_ROUTES       = 16'h0000;
    localparam logic [15:0] LOM_RST_REF_CTRL     = 16'h0000;

    // output pair operating mode
    typedef enum logic [0:0]
    {
        LOM_MODE_DIFF   = 1'b0,
        LOM_MODE_SINGLE = 1'b1
    } lom_mode_t;
endpackage : lom_pkg

// [hw/lom_line_output_mixer_control.sv]
// How it works
// R1 - first pair runs single-ended when its mode field is 1, differential when 0.
// R2 - in single-ended mode, route bit 6 sends the left mixer and bit 5 the right mixer to the first negative output.
// R3 - in differential mode, bit 2 sends the right input amp and bit 1 the left input amp to the first differential output.
// R4 - bit 0 sends the left mixer to the differential output, or to the positive output in single-ended mode.
// R5 - bit 6 mutes the first negative output and bit 5 the positive output, both muted after reset.
// R6 - bit 4 attenuates both first-pair outputs by 6 dB when set, cleared after reset.
// R7 - after reset the first pair is differential with every route disabled.
// R8 - software sets the midrail buffer enable before using the first pair single-ended.
// R9 - second pair runs single-ended when its mode field is 1, differential when 0.
// R10 - single-ended second pair routes right mixer to positive, left and right mixers to negative.
// R11 - differential second pair routes right mixer, left amp and right amp to its differential output.
// R12 - each pair's attenuate bit gives 6 dB less level, meant for several full-scale routes.
// R13 - software sets the midrail buffer enable before using the second pair single-ended.
// R14 - second pair mutes sit at bits 2 and 1, muted after reset, with its attenuate bit at 0.
// R15 - a route of the unselected mode does nothing but keeps its stored value.
`timescale 1ns/1ps
module lom_line_output_mixer_control
(
    input  wire logic        ref_clk,                   // 200 MHz clock
    input  wire logic        arst_n,                    // asynchronous reset, active low
    input  wire logic        psel,                      // apb select
    input  wire logic        penable,                   // apb access phase
    input  wire logic        pwrite,                    // apb direction
    input  wire logic [11:0] paddr,                     // apb byte address
    input  wire logic [31:0] pwdata,                    // apb write data
    input  wire logic [3:0]  pstrb,                     // apb byte strobes
    output logic      [31:0] prdata,                    // apb read data
    output logic             pready,                    // apb ready
    output logic             pslverr,                   // apb error, unmapped address
    output logic             first_pair_mode_select,    // first pair single-ended when high
    output logic             second_pair_mode_select,   // second pair single-ended when high
    output logic             left_mix_to_first_pos,     // left mixer drives first positive/diff
    output logic             left_mix_to_first_neg,     // left mixer drives first negative
    output logic             right_mix_to_first_neg,    // right mixer drives first negative
    output logic             right_amp_to_first_diff,   // right amp drives first diff output
    output logic             left_amp_to_first_diff,    // left amp drives first diff output
    output logic             right_mix_to_second_pos,   // right mixer drives second positive/diff
    output logic             left_mix_to_second_neg,    // left mixer drives second negative
    output logic             right_mix_to_second_neg,   // right mixer drives second negative
    output logic             left_amp_to_second_diff,   // left amp drives second diff output
    output logic             right_amp_to_second_diff,  // right amp drives second diff output
    output logic             first_neg_mute,            // first negative output muted
    output logic             first_pos_mute,            // first positive output muted
    output logic             second_neg_mute,           // second negative output muted
    output logic             second_pos_mute,           // second positive output muted
    output logic             first_pair_attenuate,      // first pair at -6 dB
    output logic             second_pair_attenuate,     // second pair at -6 dB
    output logic             midrail_buffer_enable      // buffered midrail reference on
);
    import lom_pkg::*;

    // reset release pair, kept apart since it is cleared by the raw reset
    typedef struct packed
    {
        logic meta;
        logic sync;
    } lom_sync_t;

    typedef struct packed
    {
        logic [15:0] vol_mute;
        logic [15:0] first_routes;
        logic [15:0] second_routes;
        logic [15:0] ref_ctrl;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic [18:0] route_out;
    } lom_state_t;

    lom_sync_t  sync_q;
    lom_state_t st_q;
    lom_state_t st_d;
    logic       rst_n;

    // merge a 16-bit register with write data under byte strobes and a writable mask
    function automatic logic [15:0] lom_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                              input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] nv;
        nv = old_v;
        if (strb[0])
            nv[7:0] = wd[7:0];
        if (strb[1])
            nv[15:8] = wd[15:8];
        return nv & mask;
    endfunction : lom_merge

    // reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync_q.meta <= 1'b0;
            sync_q.sync <= 1'b0;
        end
        else
        begin
            sync_q.meta <= 1'b1;
            sync_q.sync <= sync_q.meta;
        end
    end

    // only the second flop feeds the rest of the block
    assign rst_n = sync_q.sync;

    // next state: apb slave, register file, mode-gated route decode
    always_comb
    begin
        logic        acc;
        logic        hit;
        logic [15:0] rd16;
        lom_mode_t   m1;
        lom_mode_t   m2;
        logic [15:0] r1;
        logic [15:0] r2;
        logic        wr;
        acc  = 1'b0;
        hit  = 1'b0;
        rd16 = '0;
        wr   = 1'b0;
        m1   = LOM_MODE_DIFF;
        m2   = LOM_MODE_DIFF;
        r1   = '0;
        r2   = '0;
        st_d = st_q;
        acc = psel && !penable;
        // decode on the setup cycle, answer in the access phase
        unique case (paddr[11:2])
            {2'b00, LOM_IDX_VOLUME_MUTE}:
            begin
                hit  = 1'b1;
                rd16 = st_q.vol_mute;
            end
            {2'b00, LOM_IDX_FIRST_ROUTES}:
            begin
                hit  = 1'b1;
                rd16 = st_q.first_routes;
            end
            {2'b00, LOM_IDX_SECOND_ROUTES}:
            begin
                hit  = 1'b1;
                rd16 = st_q.second_routes;
            end
            {2'b00, LOM_IDX_REF_CTRL}:
            begin
                hit  = 1'b1;
                rd16 = st_q.ref_ctrl;
            end
            default:
            begin
                hit  = 1'b0;
                rd16 = '0;
            end
        endcase
        st_d.ready  = acc;
        st_d.slverr = acc && !hit;
        st_d.rdata  = (acc && !pwrite && hit) ? {16'h0000, rd16} : 32'h0000_0000;
        // a write lands only at the access edge, where the master sees pready high
        wr = psel && penable && st_q.ready && pwrite && hit;
        if (wr)
        begin
            if (paddr[11:2] == {2'b00, LOM_IDX_VOLUME_MUTE})
                st_d.vol_mute = lom_merge(st_q.vol_mute, pwdata, pstrb, LOM_MASK_VOLUME_MUTE); // [R5] [R6] [R14]
            if (paddr[11:2] == {2'b00, LOM_IDX_FIRST_ROUTES})
                st_d.first_routes = lom_merge(st_q.first_routes, pwdata, pstrb, LOM_MASK_ROUTES);
            if (paddr[11:2] == {2'b00, LOM_IDX_SECOND_ROUTES})
                st_d.second_routes = lom_merge(st_q.second_routes, pwdata, pstrb, LOM_MASK_ROUTES);
            if (paddr[11:2] == {2'b00, LOM_IDX_REF_CTRL})
                st_d.ref_ctrl = lom_merge(st_q.ref_ctrl, pwdata, pstrb, LOM_MASK_REF_CTRL); // [R8] [R13]
        end
        // stored values drive outputs; only the negative and amp routes are gated by the pair's current mode
        r1 = st_q.first_routes;
        r2 = st_q.second_routes;
        m1 = lom_mode_t'(r1[LOM_BIT_FIRST_MODE]);   // [R1]
        m2 = lom_mode_t'(r2[LOM_BIT_SECOND_MODE]);  // [R9]
        st_d.route_out[0]  = r1[LOM_BIT_FIRST_MODE];
        st_d.route_out[1]  = r2[LOM_BIT_SECOND_MODE];
        st_d.route_out[2]  = r1[LOM_BIT_LEFT_MIX_TO_FIRST_POS];                                    // [R4]
        st_d.route_out[3]  = (m1 == LOM_MODE_SINGLE) && r1[LOM_BIT_LEFT_MIX_TO_FIRST_NEG];          // [R2] [R15]
        st_d.route_out[4]  = (m1 == LOM_MODE_SINGLE) && r1[LOM_BIT_RIGHT_MIX_TO_FIRST_NEG];         // [R2] [R15]
        st_d.route_out[5]  = (m1 == LOM_MODE_DIFF) && r1[LOM_BIT_RIGHT_AMP_TO_FIRST_DIFF];          // [R3] [R15]
        st_d.route_out[6]  = (m1 == LOM_MODE_DIFF) && r1[LOM_BIT_LEFT_AMP_TO_FIRST_DIFF];           // [R3] [R15]
        st_d.route_out[7]  = r2[LOM_BIT_RIGHT_MIX_TO_SECOND_POS];                                  // [R10] [R11]
        st_d.route_out[8]  = (m2 == LOM_MODE_SINGLE) && r2[LOM_BIT_LEFT_MIX_TO_SECOND_NEG];         // [R10] [R15]
        st_d.route_out[9]  = (m2 == LOM_MODE_SINGLE) && r2[LOM_BIT_RIGHT_MIX_TO_SECOND_NEG];        // [R10] [R15]
        st_d.route_out[10] = (m2 == LOM_MODE_DIFF) && r2[LOM_BIT_LEFT_AMP_TO_SECOND_DIFF];          // [R11] [R15]
        st_d.route_out[11] = (m2 == LOM_MODE_DIFF) && r2[LOM_BIT_RIGHT_AMP_TO_SECOND_DIFF];         // [R11] [R15]
        st_d.route_out[12] = st_q.vol_mute[LOM_BIT_FIRST_NEG_MUTE];                                // [R5]
        st_d.route_out[13] = st_q.vol_mute[LOM_BIT_FIRST_POS_MUTE];                                // [R5]
        st_d.route_out[14] = st_q.vol_mute[LOM_BIT_SECOND_NEG_MUTE];                               // [R14]
        st_d.route_out[15] = st_q.vol_mute[LOM_BIT_SECOND_POS_MUTE];                               // [R14]
        st_d.route_out[16] = st_q.vol_mute[LOM_BIT_FIRST_ATTEN];                                   // [R6] [R12]
        st_d.route_out[17] = st_q.vol_mute[LOM_BIT_SECOND_ATTEN];                                  // [R12] [R14]
        st_d.route_out[18] = st_q.ref_ctrl[LOM_BIT_MIDRAIL_BUF_EN];
    end

    // state register, reset from the synchronised copy
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q               <= '0;
            st_q.vol_mute      <= LOM_RST_VOLUME_MUTE;  // [R5] [R14]
            st_q.first_routes  <= LOM_RST_ROUTES;       // [R7]
            st_q.second_routes <= LOM_RST_ROUTES;
            st_q.ref_ctrl      <= LOM_RST_REF_CTRL;
            st_q.route_out     <= 19'h0F000;            // all four outputs muted
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // outputs straight from flip-flops
    assign prdata                   = st_q.rdata;
    assign pready                   = st_q.ready;
    assign pslverr                  = st_q.slverr;
    assign first_pair_mode_select   = st_q.route_out[0];
    assign second_pair_mode_select  = st_q.route_out[1];
    assign left_mix_to_first_pos    = st_q.route_out[2];
    assign left_mix_to_first_neg    = st_q.route_out[3];
    assign right_mix_to_first_neg   = st_q.route_out[4];
    assign right_amp_to_first_diff  = st_q.route_out[5];
    assign left_amp_to_first_diff   = st_q.route_out[6];
    assign right_mix_to_second_pos  = st_q.route_out[7];
    assign left_mix_to_second_neg   = st_q.route_out[8];
    assign right_mix_to_second_neg  = st_q.route_out[9];
    assign left_amp_to_second_diff  = st_q.route_out[10];
    assign right_amp_to_second_diff = st_q.route_out[11];
    assign first_neg_mute           = st_q.route_out[12];
    assign first_pos_mute           = st_q.route_out[13];
    assign second_neg_mute          = st_q.route_out[14];
    assign second_pos_mute          = st_q.route_out[15];
    assign first_pair_attenuate     = st_q.route_out[16];
    assign second_pair_attenuate    = st_q.route_out[17];
    assign midrail_buffer_enable    = st_q.route_out[18];
endmodule : lom_line_output_mixer_control

// [testbench/lom_asserts.sv]
`timescale 1ns/1ps
module lom_asserts
    import lom_pkg::*;
(
    input wire logic        ref_clk,                  // clock
    input wire logic        arst_n,                   // reset, active low
    input wire logic        psel,                     // apb select
    input wire logic        penable,                  // apb access
    input wire logic        pwrite,                   // apb direction
    input wire logic [11:0] paddr,                    // apb address
    input wire logic [31:0] pwdata,                   // apb write data
    input wire logic [3:0]  pstrb,                    // apb strobes
    input wire logic [31:0] prdata,                   // apb read data
    input wire logic        pready,                   // apb ready
    input wire logic        pslverr,                  // apb error
    input wire logic        first_pair_mode_select,   // first mode
    input wire logic        first_neg_mute,           // first negative mute
    input wire logic        left_mix_to_first_neg,    // route
    input wire logic        right_amp_to_first_diff,  // route
    input wire logic        left_amp_to_first_diff,   // route
    input wire logic        second_pair_mode_select,  // second mode
    input wire logic        left_mix_to_second_neg,   // route
    input wire logic        right_mix_to_second_neg,  // route
    input wire logic        left_amp_to_second_diff,  // route
    input wire logic        right_amp_to_second_diff  // route
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // setup phase and address decode
    wire       setup  = psel && !penable;
    wire [9:0] widx   = paddr[11:2];
    wire       mapped = widx inside {{2'b00, LOM_IDX_VOLUME_MUTE}, {2'b00, LOM_IDX_FIRST_ROUTES},
                                     {2'b00, LOM_IDX_SECOND_ROUTES}, {2'b00, LOM_IDX_REF_CTRL}};
    wire       wr_first = setup && pwrite && pstrb[0] && widx == {2'b00, LOM_IDX_FIRST_ROUTES};
    wire       wr_vol   = setup && pwrite && pstrb[0] && widx == {2'b00, LOM_IDX_VOLUME_MUTE};
    property p_ready_after_setup; setup |=> pready ##1 !pready; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("pready not one pulse after setup");
    property p_no_stray_ready; !setup |=> !pready; endproperty
    a_no_stray_ready: assert property (p_no_stray_ready) else $error("pready without setup");
    property p_unmapped_err; setup |=> (pslverr == !$past(mapped)); endproperty
    a_unmapped_err: assert property (p_unmapped_err) else $error("pslverr wrong for address");
    property p_idle_rdata; !pready |-> prdata == 32'h0000_0000; endproperty
    a_idle_rdata: assert property (p_idle_rdata) else $error("prdata nonzero outside answer");
    property p_first_mode; wr_first |-> ##3 first_pair_mode_select == $past(pwdata[4], 3); endproperty
    a_first_mode: assert property (p_first_mode) else $error("first mode not from write");
    property p_first_neg_mute; wr_vol |-> ##3 first_neg_mute == $past(pwdata[6], 3); endproperty
    a_first_neg_mute: assert property (p_first_neg_mute) else $error("first negative mute not from write");
    property p_first_se_gate; left_mix_to_first_neg |-> first_pair_mode_select; endproperty
    a_first_se_gate: assert property (p_first_se_gate) else $error("first negative route in diff mode");
    property p_first_diff_gate; right_amp_to_first_diff || left_amp_to_first_diff |-> !first_pair_mode_select;
    endproperty
    a_first_diff_gate: assert property (p_first_diff_gate) else $error("first amp route in se mode");
    property p_second_se_gate; left_mix_to_second_neg || right_mix_to_second_neg |-> second_pair_mode_select;
    endproperty
    a_second_se_gate: assert property (p_second_se_gate) else $error("second negative route in diff mode");
    property p_second_diff_gate; left_amp_to_second_diff || right_amp_to_second_diff |-> !second_pair_mode_select;
    endproperty
    a_second_diff_gate: assert property (p_second_diff_gate) else $error("second amp route in se mode");
    // main scenarios reached
    c_write_first: cover property (wr_first);
    c_error: cover property (pslverr);
    c_single: cover property (left_mix_to_first_neg || left_mix_to_second_neg);
endmodule : lom_asserts
bind lom_line_output_mixer_control lom_asserts u_lom_asserts (.ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .first_pair_mode_select, .first_neg_mute, .left_mix_to_first_neg,
    .right_amp_to_first_diff, .left_amp_to_first_diff, .second_pair_mode_select, .left_mix_to_second_neg,
    .right_mix_to_second_neg, .left_amp_to_second_diff, .right_amp_to_second_diff);

// [testbench/tb_line_output_mixer_control.sv]
`timescale 1ns/1ps
module tb_line_output_mixer_control;
    import lom_pkg::*;
    logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [5:0]  o1, o2;
    logic [6:0]  ov;
    int          mismatches, n_checks;
    // device under test, outputs gathered into vectors
    lom_line_output_mixer_control DUT (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .first_pair_mode_select(o1[5]), .left_mix_to_first_neg(o1[4]),
        .right_mix_to_first_neg(o1[3]), .right_amp_to_first_diff(o1[2]), .left_amp_to_first_diff(o1[1]),
        .left_mix_to_first_pos(o1[0]), .second_pair_mode_select(o2[5]), .right_mix_to_second_neg(o2[4]),
        .left_mix_to_second_neg(o2[3]), .left_amp_to_second_diff(o2[2]), .right_amp_to_second_diff(o2[1]),
        .right_mix_to_second_pos(o2[0]), .first_neg_mute(ov[6]), .first_pos_mute(ov[5]),
        .first_pair_attenuate(ov[4]), .midrail_buffer_enable(ov[3]), .second_neg_mute(ov[2]),
        .second_pos_mute(ov[1]), .second_pair_attenuate(ov[0]));
    task test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // one apb transfer; holds the request until pready is sampled high
    task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int i;
        @(posedge ref_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (i == 20)
        begin
            mismatches++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // decoded outputs follow one edge after the write lands
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : apb
    task t_reset;
        chk("outputs", {o1, o2, ov}, {12'h000, 7'h66});
        apb(1'b0, 12'(LOM_ADDR_VOLUME_MUTE), 16'h0000);
        chk("volume reset", rd, 32'h66);
        apb(1'b0, 12'(LOM_ADDR_FIRST_ROUTES), 16'h0000);
        chk("routes reset", rd, 32'h0);
    endtask : t_reset
    // both route registers map onto their output vectors through the same bit mapping, with the mode bit at the top of the vector
    task t_pair(input logic [11:0] a, input bit k);
        apb(1'b1, a, 16'h0077);
        chk("se routes", k ? o2 : o1, 6'h39);
        apb(1'b0, a, 16'h0000);
        chk("routes read", rd, 32'h77);
        apb(1'b1, a, 16'h0067);
        chk("diff routes", k ? o2 : o1, 6'h07);
        apb(1'b1, a, 16'h0000);
        chk("routes off", k ? o2 : o1, 6'h00);
    endtask : t_pair
    task t_volume;
        apb(1'b1, 12'(LOM_ADDR_VOLUME_MUTE), 16'hFFFF);
        chk("vol all", ov, 7'h77);
        apb(1'b0, 12'(LOM_ADDR_VOLUME_MUTE), 16'h0000);
        chk("vol reserved", rd, 32'h77);
        apb(1'b1, 12'(LOM_ADDR_VOLUME_MUTE), 16'h0011);
        chk("vol atten", ov, 7'h11);
    endtask : t_volume
    task t_ref_and_error;
        apb(1'b1, 12'(LOM_ADDR_REF_CTRL), 16'h0001);
        chk("midrail", ov, 7'h19);
        apb(1'b1, 12'h100, 16'hFFFF);
        chk("bad write err", err, 1'b1);
        apb(1'b0, 12'h100, 16'h0000);
        chk("bad read data", rd, 32'h0);
        chk("bad read err", err, 1'b1);
        chk("no side effect", ov, 7'h19);
    endtask : t_ref_and_error
    // clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // main sequence
    initial
    begin
        arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h3; mismatches = 0; n_checks = 0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        t_reset();
        t_pair(12'(LOM_ADDR_FIRST_ROUTES), 1'b0);
        t_pair(12'(LOM_ADDR_SECOND_ROUTES), 1'b1);
        t_volume();
        t_ref_and_error();
        test_done();
    end
endmodule : tb_line_output_mixer_control
